// ---- logic/bdi_pkg.sv ----
// shared constants, types and template table for bundle decode and issue
package bdi_pkg;

  // ------------------------------------------------------------
  // bundle layout
  // ------------------------------------------------------------
  localparam int BUNDLE_W = 128;
  localparam int SLOTS = 3;
  localparam int SLOT_W = 41;
  localparam int TMPL_W = 5;
  localparam int TMPL_STOP_BIT = 0;
  localparam int TMPL_ARR_LSB = 1;
  localparam int ARR_W = 4;
  localparam int SLOT_LSB = TMPL_W;
  localparam int GUARD_LSB = 0;
  localparam int BUNDLE_BYTES = 16;

  // ------------------------------------------------------------
  // addresses and predicates
  // ------------------------------------------------------------
  localparam int ADDR_W = 64;
  localparam logic [63:0] RESET_VECTOR = 64'h0;
  localparam int PRED_N = 64;
  localparam int PRED_AW = 6;
  localparam int PRED_WR_PORTS = 2;
  localparam logic [5:0] ALWAYS_TRUE_PREDICATE = 6'h0;

  // ------------------------------------------------------------
  // slot arrangements
  // ------------------------------------------------------------
  localparam int ARR_N = 12;
  localparam logic [3:0] ARR_MLX = 4'h2;
  localparam logic [3:0] TEMPLATE_STOP_AFTER_FIRST = 4'h1;
  localparam logic [3:0] TEMPLATE_STOP_AFTER_SECOND = 4'h4;

  typedef enum logic [2:0] {
    UNIT_M = 3'h0,
    UNIT_I = 3'h1,
    UNIT_F = 3'h2,
    UNIT_B = 3'h3,
    UNIT_L = 3'h4,
    UNIT_X = 3'h5
  } bdi_unit_e;

  typedef struct packed {
    logic legal;
    logic [8:0] unit;
    logic [2:0] stops;
  } bdi_arr_s;

  typedef enum logic [1:0] {
    ST_EMPTY = 2'b00,
    ST_AT0 = 2'b01,
    ST_AT1 = 2'b11,
    ST_AT2 = 2'b10
  } bdi_state_e;

  // unit per slot (slot 0 lowest) and stops inside the bundle
  function automatic bdi_arr_s bdi_arrange(input logic [3:0] idx);
    bdi_arr_s a;
    a.legal = 1'b1;
    a.stops = 3'b000;
    unique case (idx)
      4'h0: a.unit = {UNIT_I, UNIT_I, UNIT_M};
      TEMPLATE_STOP_AFTER_FIRST: begin
        a.unit = {UNIT_I, UNIT_I, UNIT_M};
        a.stops = 3'b001;
      end
      ARR_MLX: a.unit = {UNIT_X, UNIT_L, UNIT_M};
      4'h3: a.unit = {UNIT_I, UNIT_M, UNIT_M};
      TEMPLATE_STOP_AFTER_SECOND: begin
        a.unit = {UNIT_I, UNIT_M, UNIT_M};
        a.stops = 3'b010;
      end
      4'h5: a.unit = {UNIT_I, UNIT_F, UNIT_M};
      4'h6: a.unit = {UNIT_F, UNIT_M, UNIT_M};
      4'h7: a.unit = {UNIT_B, UNIT_I, UNIT_M};
      4'h8: a.unit = {UNIT_B, UNIT_B, UNIT_M};
      4'h9: a.unit = {UNIT_B, UNIT_B, UNIT_B};
      4'ha: a.unit = {UNIT_B, UNIT_M, UNIT_M};
      4'hb: a.unit = {UNIT_B, UNIT_F, UNIT_M};
      default: begin
        a.legal = 1'b0;
        a.unit = 9'h0;
      end
    endcase
    return a;
  endfunction

endpackage

// ---- logic/bdi_pred_if.sv ----
// predicate file read and write port bundle
`timescale 1ns/100ps
interface bdi_pred_if;
  logic [bdi_pkg::SLOTS-1:0] rd_en;
  logic [bdi_pkg::SLOTS*bdi_pkg::PRED_AW-1:0] rd_addr;
  logic [bdi_pkg::SLOTS-1:0] rd_data;
  logic [bdi_pkg::PRED_WR_PORTS-1:0] wr_en;
  logic [bdi_pkg::PRED_WR_PORTS*bdi_pkg::PRED_AW-1:0] wr_addr;
  logic [bdi_pkg::PRED_WR_PORTS-1:0] wr_val;

  modport owner (
    input rd_en,
    input rd_addr,
    input wr_en,
    input wr_addr,
    input wr_val,
    output rd_data
  );

  modport user (
    output rd_en,
    output rd_addr,
    output wr_en,
    output wr_addr,
    output wr_val,
    input rd_data
  );
endinterface

// ---- logic/bdi_pred_file.sv ----
// predicate register file with registered read ports
`timescale 1ns/100ps
module bdi_pred_file #(
  parameter int N_PRED = bdi_pkg::PRED_N
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  bdi_pred_if.owner pif
);

  localparam int AW = bdi_pkg::PRED_AW;
  localparam int WP = bdi_pkg::PRED_WR_PORTS;

  if (N_PRED != (1 << AW)) begin : g_chk
    $error("N_PRED must match the predicate address width");
  end

  logic [N_PRED-1:0] pbits;

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  // entry zero fixed
  assign pbits[0] = 1'b1;

  for (genvar i = 1; i < N_PRED; i++) begin : g_bit
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        pbits[i] <= 1'b0;
      end else if (ce) begin
        for (int w = WP - 1; w >= 0; w--) begin
          if (pif.wr_en[w] && pif.wr_addr[w*AW +: AW] == AW'(i)) begin
            pbits[i] <= pif.wr_val[w];
          end
        end
      end
    end
  end

  // ------------------------------------------------------------
  // read ports
  // ------------------------------------------------------------
  for (genvar p = 0; p < bdi_pkg::SLOTS; p++) begin : g_rd
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        pif.rd_data[p] <= 1'b0;
      end else if (ce) begin
        pif.rd_data[p] <= pif.rd_en[p] & pbits[pif.rd_addr[p*AW +: AW]];
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  always_true_read_a: assert property (
    @(posedge clk) disable iff (!nrst)
    ce && pif.rd_en[0] && pif.rd_addr[AW-1:0] == 6'h0 |=> pif.rd_data[0])
    else $error("predicate zero did not read true");

  pred_write_kept_a: assert property (
    @(posedge clk) disable iff (!nrst)
    ce && pif.wr_en[0] && pif.wr_addr[AW-1:0] != 6'h0
      && !(pif.wr_en[1] && pif.wr_addr[2*AW-1:AW] == pif.wr_addr[AW-1:0])
    |=> pbits[$past(pif.wr_addr[AW-1:0])] == $past(pif.wr_val[0]))
    else $error("predicate write not stored");

endmodule

// ---- logic/bdi_decode_issue.sv ----
// bundle decode, group formation and predicated issue front end
`timescale 1ns/100ps
// Operation
// - bundle is 128 bits, three 41-bit slots
// - low five bits form the template field
// - twelve arrangements, each with/without final stop
// - two arrangements stop after slot zero/one
// - groups end at stops and taken branches
// - a group may issue over several cycles
// - true guard commits, false guard discards silently
// - compare results write predicate registers
// - bundles are little-endian in fetch bytes
// - fetch address and bundle pointer 64 bits
// - sixty-four one-bit predicate registers
// - predicate zero reads true, writes dropped
module bdi_decode_issue #(
  parameter int ISSUE_WIDTH = 2
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CE,
  output logic [bdi_pkg::ADDR_W-1:0] FETCH_ADDR,
  input wire logic FETCH_VALID,
  input wire logic [bdi_pkg::BUNDLE_W-1:0] FETCH_DATA,
  output logic FETCH_READY,
  input wire logic BRANCH_TAKEN,
  input wire logic [bdi_pkg::ADDR_W-1:0] BRANCH_TARGET,
  input wire logic ISSUE_READY,
  output logic ISSUE_VALID,
  output logic [bdi_pkg::SLOTS-1:0] ISSUE_MASK,
  output logic [bdi_pkg::SLOTS*bdi_pkg::SLOT_W-1:0] ISSUE_INSN,
  output logic [bdi_pkg::SLOTS*3-1:0] ISSUE_UNIT,
  output logic [bdi_pkg::SLOTS-1:0] ISSUE_COMMIT,
  output logic ISSUE_GROUP_START,
  output logic ISSUE_GROUP_END,
  output logic [bdi_pkg::ADDR_W-1:0] BUNDLE_PTR,
  output logic ILLEGAL_OP,
  input wire logic [bdi_pkg::PRED_WR_PORTS-1:0] PRED_WR_EN,
  input wire logic [bdi_pkg::PRED_WR_PORTS*bdi_pkg::PRED_AW-1:0] PRED_WR_ADDR,
  input wire logic [bdi_pkg::PRED_WR_PORTS-1:0] PRED_WR_VAL
);

  localparam int SW = bdi_pkg::SLOT_W;
  localparam int AW = bdi_pkg::PRED_AW;

  if (ISSUE_WIDTH < 2 || ISSUE_WIDTH > bdi_pkg::SLOTS) begin : g_chk
    $error("ISSUE_WIDTH must be 2 or 3");
  end

  bdi_pkg::bdi_state_e state;
  bdi_pkg::bdi_state_e next_state;
  logic [bdi_pkg::BUNDLE_W-1:0] bund;
  logic [bdi_pkg::ADDR_W-1:0] bptr;
  logic grp_new;
  bdi_pkg::bdi_arr_s arr;
  bdi_pkg::bdi_arr_s arr_in;
  logic [2:0] stops;
  logic [1:0] cur;
  logic [3:0] pick;
  logic issue_go;
  logic accept;
  logic legal_in;

  bdi_pred_if pif ();

  bdi_pred_file u_pred (
    .clk(CLK),
    .nrst(NRST),
    .ce(CE),
    .pif(pif.owner)
  );

  // ------------------------------------------------------------
  // template decode
  // ------------------------------------------------------------
  // template field taken
  assign arr = bdi_pkg::bdi_arrange(bund[bdi_pkg::TMPL_ARR_LSB +: 4]);
  assign arr_in = bdi_pkg::bdi_arrange(FETCH_DATA[bdi_pkg::TMPL_ARR_LSB +: 4]);
  assign legal_in = arr_in.legal;
  assign stops = {bund[bdi_pkg::TMPL_STOP_BIT], arr.stops[1:0]};

  always_comb begin
    unique case (state)
      bdi_pkg::ST_EMPTY: cur = 2'd0;
      bdi_pkg::ST_AT0: cur = 2'd0;
      bdi_pkg::ST_AT1: cur = 2'd1;
      bdi_pkg::ST_AT2: cur = 2'd2;
    endcase
  end

  // slots issued this cycle and whether a stop closes them
  function automatic logic [3:0] pick_slots(input logic [1:0] c,
                                            input logic [2:0] st,
                                            input logic lx);
    logic [2:0] m;
    logic ge;
    logic open;
    int n;
    m = 3'b000;
    ge = 1'b0;
    open = 1'b1;
    n = 0;
    for (int s = 0; s < 3; s++) begin
      if (s >= int'(c) && open && n < ISSUE_WIDTH) begin
        m[s] = 1'b1;
        n = n + 1;
        if (st[s]) begin
          open = 1'b0;
          ge = 1'b1;
        end
      end
    end
    if (lx && m[1] && !m[2]) begin
      m[1] = 1'b0;
    end
    return {ge, m};
  endfunction

  assign pick = pick_slots(cur, stops,
                           bund[bdi_pkg::TMPL_ARR_LSB +: 4] == bdi_pkg::ARR_MLX);

  // ------------------------------------------------------------
  // handshakes
  // ------------------------------------------------------------
  assign issue_go = CE && state != bdi_pkg::ST_EMPTY && ISSUE_READY
                    && !BRANCH_TAKEN;
  assign FETCH_READY = CE && !BRANCH_TAKEN
                       && (state == bdi_pkg::ST_EMPTY || (issue_go && pick[2]));
  assign accept = FETCH_VALID && FETCH_READY;

  always_comb begin
    next_state = state;
    if (BRANCH_TAKEN) begin
      next_state = bdi_pkg::ST_EMPTY;
    end else if (accept) begin
      next_state = legal_in ? bdi_pkg::ST_AT0 : bdi_pkg::ST_EMPTY;
    end else if (issue_go) begin
      if (pick[2]) begin
        next_state = bdi_pkg::ST_EMPTY;
      end else if (pick[1]) begin
        next_state = bdi_pkg::ST_AT2;
      end else begin
        next_state = bdi_pkg::ST_AT1;
      end
    end
  end

  // ------------------------------------------------------------
  // bundle holding and fetch address
  // ------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state <= bdi_pkg::ST_EMPTY;
    end else if (CE) begin
      state <= next_state;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      bund <= '0;
      bptr <= bdi_pkg::RESET_VECTOR;
    end else if (accept && legal_in) begin
      bund <= FETCH_DATA;
      bptr <= FETCH_ADDR;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      FETCH_ADDR <= bdi_pkg::RESET_VECTOR;
    end else if (CE && BRANCH_TAKEN) begin
      FETCH_ADDR <= BRANCH_TARGET;
    end else if (accept) begin
      FETCH_ADDR <= FETCH_ADDR + 64'(bdi_pkg::BUNDLE_BYTES);
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ILLEGAL_OP <= 1'b0;
    end else if (CE) begin
      ILLEGAL_OP <= accept && !legal_in;
    end
  end

  // ------------------------------------------------------------
  // group tracking and issue
  // ------------------------------------------------------------
  // group closes at stop or branch
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      grp_new <= 1'b1;
    end else if (CE) begin
      if (BRANCH_TAKEN) begin
        grp_new <= 1'b1;
      end else if (issue_go) begin
        grp_new <= pick[3];
      end
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ISSUE_VALID <= 1'b0;
      ISSUE_MASK <= 3'h0;
      ISSUE_GROUP_START <= 1'b0;
      ISSUE_GROUP_END <= 1'b0;
      BUNDLE_PTR <= bdi_pkg::RESET_VECTOR;
    end else if (CE) begin
      ISSUE_VALID <= issue_go;
      ISSUE_MASK <= issue_go ? pick[2:0] : 3'h0;
      ISSUE_GROUP_START <= issue_go && grp_new;
      ISSUE_GROUP_END <= issue_go && pick[3];
      if (issue_go) begin
        BUNDLE_PTR <= bptr;
      end
    end
  end

  for (genvar s = 0; s < bdi_pkg::SLOTS; s++) begin : g_slot
    always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
        ISSUE_INSN[s*SW +: SW] <= '0;
        ISSUE_UNIT[s*3 +: 3] <= 3'h0;
      end else if (issue_go) begin
        ISSUE_INSN[s*SW +: SW] <= bund[bdi_pkg::SLOT_LSB + s*SW +: SW];
        ISSUE_UNIT[s*3 +: 3] <= arr.unit[s*3 +: 3];
      end
    end
    assign pif.rd_en[s] = issue_go && pick[s];
    assign pif.rd_addr[s*AW +: AW] =
      bund[bdi_pkg::SLOT_LSB + s*SW + bdi_pkg::GUARD_LSB +: AW];
  end

  assign pif.wr_en = PRED_WR_EN & {bdi_pkg::PRED_WR_PORTS{CE}};
  assign pif.wr_addr = PRED_WR_ADDR;
  assign pif.wr_val = PRED_WR_VAL;
  assign ISSUE_COMMIT = pif.rd_data;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // branch pending until next issue
  logic since_branch;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      since_branch <= 1'b0;
    end else if (CE) begin
      since_branch <= BRANCH_TAKEN || (since_branch && !issue_go);
    end
  end

  illegal_not_issued_a: assert property (
    @(posedge CLK) disable iff (!NRST)
    accept && !legal_in && !BRANCH_TAKEN
    |=> ILLEGAL_OP && state == bdi_pkg::ST_EMPTY
      ##1 (!ISSUE_VALID || !$past(CE)))
    else $error("illegal template dispatched");
  issue_width_a: assert property (
    @(posedge CLK) disable iff (!NRST)
    ISSUE_VALID |-> $countones(ISSUE_MASK) <= ISSUE_WIDTH)
    else $error("too many slots issued");
  stop_first_a: assert property (
    @(posedge CLK) disable iff (!NRST)
    issue_go && cur == 2'd0
      && bund[bdi_pkg::TMPL_ARR_LSB +: 4] == bdi_pkg::TEMPLATE_STOP_AFTER_FIRST
    |=> ISSUE_MASK == 3'b001 && ISSUE_GROUP_END)
    else $error("mid stop after first slot missed");
  final_stop_a: assert property (
    @(posedge CLK) disable iff (!NRST)
    issue_go && pick[2] |=>
      ISSUE_GROUP_END == $past(bund[bdi_pkg::TMPL_STOP_BIT]))
    else $error("final stop bit not honoured");
  group_restart_a: assert property (
    @(posedge CLK) disable iff (!NRST)
    issue_go && since_branch |=> ISSUE_GROUP_START)
    else $error("taken branch did not end the group");

  fetch_step_a: assert property (
    @(posedge CLK) disable iff (!NRST)
    accept |=> FETCH_ADDR == $past(FETCH_ADDR) + 64'(bdi_pkg::BUNDLE_BYTES))
    else $error("fetch address did not step one bundle");
  redirect_a: assert property (
    @(posedge CLK) disable iff (!NRST)
    CE && BRANCH_TAKEN |=> FETCH_ADDR == $past(BRANCH_TARGET)
      && state == bdi_pkg::ST_EMPTY && !ISSUE_VALID)
    else $error("taken branch not redirected");
  commit_in_mask_a: assert property (
    @(posedge CLK) disable iff (!NRST)
    ISSUE_VALID |-> (ISSUE_COMMIT & ~ISSUE_MASK) == 3'h0)
    else $error("commit outside issued slots");
  slot_zero_a: assert property (
    @(posedge CLK) disable iff (!NRST)
    issue_go |=> ISSUE_INSN[SW-1:0] == $past(bund[bdi_pkg::SLOT_LSB +: SW]))
    else $error("slot zero misplaced");

  mid_stop_c: cover property (@(posedge CLK) disable iff (!NRST)
    ISSUE_VALID && ISSUE_GROUP_END && !ISSUE_MASK[2]);
  illegal_c: cover property (@(posedge CLK) disable iff (!NRST) ILLEGAL_OP);
  branch_hold_c: cover property (@(posedge CLK) disable iff (!NRST)
    BRANCH_TAKEN && state != bdi_pkg::ST_EMPTY);
  span_c: cover property (@(posedge CLK) disable iff (!NRST)
    ISSUE_VALID && ISSUE_MASK[0] && !ISSUE_GROUP_START);

endmodule

// ---- test/bdi_fetch_model.sv ----
// fetch path model serving bundles from a small byte store
`timescale 1ns/100ps
module bdi_fetch_model (
  input wire logic clk,
  input wire logic gap,
  input wire logic [63:0] addr,
  output logic valid,
  output logic [127:0] data
);
  logic [7:0] mem [512];

  initial begin
    valid = 1'b0;
    data = 128'h0;
  end

  // --------------------
  // store and delivery
  // --------------------
  task automatic put(input logic [4:0] idx, input logic [127:0] b);
    for (int k = 0; k < 16; k++) begin
      mem[{idx, 4'h0} + 9'(k)] = b[8*k +: 8];
    end
  endtask

  always @(negedge clk) begin
    valid <= !gap;
    if (gap) begin
      data <= ~data;
    end else begin
      for (int k = 0; k < 16; k++) begin
        data[8*k +: 8] <= mem[{addr[8:4], 4'h0} + 9'(k)];
      end
    end
  end
endmodule

// ---- test/bdi_decode_issue_bench.sv ----
// self-checking bench for bundle decode and issue
`timescale 1ns/100ps
module bdi_decode_issue_bench;
  localparam int W = 2;
  localparam logic [107:0] UTAB = {9'h0d0, 9'h0c0, 9'h0db, 9'h0d8, 9'h0c8,
    9'h080, 9'h050, 9'h040, 9'h040, 9'h160, 9'h048, 9'h048};
  typedef struct packed {
    logic [2:0] mask;
    logic fin;
    logic [122:0] insn;
    logic [8:0] unit;
    logic [63:0] ptr;
  } bdi_exp_s;

  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b0;
  logic gap = 1'b1;
  logic btaken = 1'b0;
  logic iready = 1'b0;
  logic [63:0] btarget = 64'h0;
  logic [1:0] pwen = 2'b00;
  logic [11:0] pwaddr = 12'h0;
  logic [1:0] pwval = 2'b00;
  logic fvalid, fready, ivalid, gstart, gend, illegal;
  logic [63:0] fetch_addr, bptr;
  logic [127:0] fetch_data, b;
  logic [2:0] imask, icommit;
  logic [122:0] iinsn;
  logic [8:0] iunit;
  logic [63:0] pred = 64'h1;
  logic [63:0] exp_fa = 64'h0;
  logic [1:0] pend_en = 2'b00;
  logic [11:0] pend_a;
  logic [1:0] pend_v;
  logic [31:0] rnd = 32'h808ba0b0;
  logic exp_start = 1'b1;
  logic last_stall = 1'b0;
  logic last_frz = 1'b0;
  bdi_exp_s q [$];
  int exp_ill = 0;
  int obs_ill = 0;
  int mismatches = 0;
  int cmp_count = 0;

  always #10 clk = ~clk;

  bdi_decode_issue #(.ISSUE_WIDTH(W)) u_dut (.CLK(clk), .NRST(nrst),
    .CE(ce), .FETCH_ADDR(fetch_addr), .FETCH_VALID(fvalid),
    .FETCH_DATA(fetch_data), .FETCH_READY(fready), .BRANCH_TAKEN(btaken),
    .BRANCH_TARGET(btarget), .ISSUE_READY(iready), .ISSUE_VALID(ivalid),
    .ISSUE_MASK(imask), .ISSUE_INSN(iinsn), .ISSUE_UNIT(iunit),
    .ISSUE_COMMIT(icommit), .ISSUE_GROUP_START(gstart),
    .ISSUE_GROUP_END(gend), .BUNDLE_PTR(bptr), .ILLEGAL_OP(illegal),
    .PRED_WR_EN(pwen), .PRED_WR_ADDR(pwaddr), .PRED_WR_VAL(pwval));

  bdi_fetch_model u_fetch (.clk(clk), .gap(gap), .addr(fetch_addr),
    .valid(fvalid), .data(fetch_data));

  // --------------------
  // helpers
  // --------------------
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], 1'b0} ^ (v[31] ? 32'h04c11db7 : 32'h0);
  endfunction

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic accept(input logic [127:0] d, input logic [63:0] a);
    logic [3:0] arr;
    logic [2:0] stp;
    int s;
    int n;
    bdi_exp_s e;
    arr = d[4:1];
    if (arr > 4'hb) begin
      exp_ill++;
      return;
    end
    stp = {d[0], arr == 4'h4, arr == 4'h1};
    s = 0;
    while (s < 3) begin
      e = '0;
      n = 0;
      do begin
        e.mask[s] = 1'b1;
        e.fin = stp[s];
        s++;
        n++;
      end while (s < 3 && n < W && !e.fin && !(arr == 4'h2 && s == 1 && W < 3));
      e.insn = d[127:5];
      e.unit = UTAB[9*arr +: 9];
      e.ptr = a;
      q.push_back(e);
    end
  endtask

  task automatic on_issue();
    bdi_exp_s e;
    logic [2:0] cm;
    if (q.size() == 0) begin
      check(ivalid, 1'b0);
      return;
    end
    e = q.pop_front();
    for (int s = 0; s < 3; s++) begin
      cm[s] = e.mask[s] & pred[e.insn[41*s +: 6]];
      if (e.mask[s]) begin
        check(iinsn[41*s +: 41], e.insn[41*s +: 41]);
        check(iunit[3*s +: 3], e.unit[3*s +: 3]);
      end
    end
    check(imask, e.mask);
    check(icommit, cm);
    check(gend, e.fin);
    check(gstart, exp_start);
    check(bptr, e.ptr);
    exp_start = e.fin;
  endtask

  task automatic step(input logic r, input logic c, input logic br,
    input logic [63:0] t, input logic [1:0] we, input logic [11:0] wa,
    input logic [1:0] wv, input logic g);
    if (last_stall) begin
      check(ivalid, 1'b0);
    end else if (!last_frz && ivalid === 1'b1) begin
      on_issue();
    end
    if (!last_frz && illegal === 1'b1) begin
      obs_ill++;
    end
    check(fetch_addr, exp_fa);
    for (int w = 1; w >= 0; w--) begin
      if (pend_en[w] && pend_a[6*w +: 6] != 6'h0) begin
        pred[pend_a[6*w +: 6]] = pend_v[w];
      end
    end
    iready = r;
    ce = c;
    btaken = br;
    btarget = t;
    pwen = we;
    pwaddr = wa;
    pwval = wv;
    gap <= g;
    #1;
    check(fready, c && !br && (q.size() < 1 || r && q.size() < 2));
    last_stall = c & (!r | br);
    last_frz = !c;
    pend_en = c ? we : 2'b00;
    pend_a = wa;
    pend_v = wv;
    if (c && br) begin
      q.delete();
      exp_start = 1'b1;
      exp_fa = t;
    end else if (c && fvalid === 1'b1 && fready === 1'b1) begin
      accept(fetch_data, fetch_addr);
      exp_fa = fetch_addr + 64'h10;
    end
    @(negedge clk);
  endtask

  task automatic do_reset();
    nrst = 1'b0;
    repeat (10) @(negedge clk);
    check({ivalid, illegal, imask, gstart, gend, icommit}, 128'h0);
    check({fetch_addr, bptr}, 128'h0);
    nrst = 1'b1;
    q.delete();
    exp_start = 1'b1;
    exp_fa = 64'h0;
    pred = 64'h1;
    pend_en = 2'b00;
    last_stall = 1'b0;
    last_frz = 1'b0;
  endtask

  // --------------------
  // sequence
  // --------------------
  initial begin
    for (int i = 0; i < 32; i++) begin
      for (int k = 0; k < 4; k++) begin
        rnd = lfsr(rnd);
        b[32*k +: 32] = rnd;
      end
      b[4:0] = {i[3:0], i[4]};
      u_fetch.put(5'(i), b);
    end
    do_reset();
    for (int i = 0; i < 64; i++) begin
      rnd = lfsr(rnd);
      step(1'b0, 1'b1, 1'b0, 64'h0, 2'b11, {2{6'(i)}}, rnd[1:0], 1'b0);
    end
    for (int rep = 0; rep < 2; rep++) begin
      step(1'b1, 1'b1, 1'b1, 64'hffff_ffff_ffff_ffe0, 2'b00, 12'h0, 2'b00,
        1'b0);
      for (int i = 0; i < 800; i++) begin
        rnd = lfsr(rnd);
        step(rnd[1:0] != 2'b00, rnd[4:2] != 3'b000, rnd[9:5] == 5'h00,
          {rnd ^ 32'h3c5a96e1, rnd[31:4], 4'h0}, rnd[13:12],
          rnd[26] ? {2{rnd[19:14]}} : rnd[25:14], rnd[28:27],
          rnd[11:10] == 2'b00);
      end
      for (int i = 0; i < 12; i++) begin
        step(1'b1, 1'b1, 1'b0, 64'h0, 2'b00, 12'h0, 2'b00, 1'b1);
      end
      check(128'(q.size()), 128'h0);
      check(128'(obs_ill), 128'(exp_ill));
      exp_ill = 0;
      obs_ill = 0;
      do_reset();
    end
    tally_and_finish();
  end

  initial begin
    #200000;
    mismatches++;
    tally_and_finish();
  end
endmodule
